// *** design/rcf_pkg.sv ***
package rcf_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RESUME = 8'h04;
	localparam logic [7:0] OFF_RESULT = 8'h08;
	localparam logic [7:0] OFF_POS_OUT = 8'h0C;
	localparam logic [7:0] OFF_VECTOR = 8'h10;
	localparam logic [7:0] OFF_EVT_STAT = 8'h14;
	localparam logic [7:0] OFF_EVT_EN = 8'h18;
	localparam logic [7:0] OFF_EVT_CLR = 8'h1C;

	// ----------------------------------------------------------------
	// Control and result field positions
	// ----------------------------------------------------------------
	localparam int CTRL_TGT_LSB = 0;
	localparam int CTRL_INV_BIT = 4;
	localparam int CTRL_POLL_BIT = 5;
	localparam int CTRL_GO_BIT = 31;
	localparam int RES_BUSY_BIT = 31;

	// ----------------------------------------------------------------
	// Target codes and status codes
	// ----------------------------------------------------------------
	localparam logic [2:0] TGT_INSTR = 3'h1;
	localparam logic [2:0] TGT_DATA = 3'h2;
	localparam logic [2:0] TGT_ALL = 3'h3;
	localparam logic [2:0] TGT_COHERE = 3'h4;
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_PENDING = 8'h01;
	localparam logic [7:0] ST_OK_PMI = 8'h02;
	localparam logic [7:0] ST_BAD_ARG = 8'hFE;

	// ----------------------------------------------------------------
	// Geometry and walk index
	// ----------------------------------------------------------------
	localparam int SET_W = 6;
	localparam int WAY_W = 2;
	localparam int IDX_W = 1 + SET_W + WAY_W;
	localparam int POS_W = IDX_W + 1;
	localparam logic [IDX_W-1:0] IDX_D_FIRST = 9'h000;
	localparam logic [IDX_W-1:0] IDX_D_LAST = 9'h0FF;
	localparam logic [IDX_W-1:0] IDX_I_FIRST = 9'h100;
	localparam logic [IDX_W-1:0] IDX_I_LAST = 9'h1FF;

	// ----------------------------------------------------------------
	// Events and reset values
	// ----------------------------------------------------------------
	localparam int EVT_N = 3;
	localparam int EVT_DONE = 0;
	localparam int EVT_STOP = 1;
	localparam int EVT_REJECT = 2;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LAUNCH = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT = 3'b011,
		ST_STEP = 3'b100
	} rcf_state_t;

endpackage : rcf_pkg

// *** design/rcf_evt_bit.sv ***
`timescale 1ns/10ps
module rcf_evt_bit (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_set,
	input wire logic i_clr,
	output logic o_flag
);

	// A set in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clr) begin
			o_flag <= 1'b0;
		end
	end

endmodule : rcf_evt_bit

// *** design/rcf_flush_seq.sv ***
// Overview of operation
// RL1: With invalidate set, each visited line ends invalid; modified data written back first. Target 4 keeps data lines valid.
// RL2: Caller starts every new flush with resume position zero.
// RL3: Caller supplies only zero or the last reported position; else undefined.
// RL4: One pass visits every set and way of each selected cache.
// RL5: All lines resident at the position-zero start get flushed despite interrupt splits.
// RL6: Prefetches flushed by target: instruction for 1 and 4, data 2, both 3.
// RL7: At least one line is flushed before pending interrupts are sampled.
// RL8: Early stop on pending unmasked interrupt reports status 1.
// RL9: Completed pass without error reports status 0.
// RL10: Completed pass with a management interrupt taken reports status 2.
// RL11: On status 1 report vector, acknowledge the interrupt, marking it in service.
// RL12: Caller services the reported vector then signals end of interrupt.
// RL13: On status 1 report the current position in the pass.
// RL14: Nonzero resume position continues the pass from that point.
// RL15: Caller removes speculative translations or disables translation beforehand.
// RL16: Target codes: 1 instruction, 2 data, 3 all, 4 instruction coherent with data.
// RL17: With polling clear, interrupts are ignored until the whole pass is done.
// RL18: With invalidate clear, modified lines are written back and stay valid clean. Target 4 invalidates instruction lines.
// RL19: Reserved target code is rejected with invalid-argument status, caches untouched.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
module rcf_flush_seq (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	output logic o_line_req,
	output logic o_line_instr,
	output logic [rcf_pkg::SET_W-1:0] o_line_set,
	output logic [rcf_pkg::WAY_W-1:0] o_line_way,
	output logic o_line_inv,
	input wire logic i_line_ack,
	output logic o_pf_flush_instr,
	output logic o_pf_flush_data,
	input wire logic i_ext_irq_pending,
	input wire logic [7:0] i_ext_irq_vector,
	output logic o_ext_irq_ack,
	input wire logic i_platform_mgmt_irq,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [2:0] cfg_target;
	logic cfg_inv;
	logic cfg_poll;
	logic [31:0] resume_pos;
	logic [7:0] result;
	logic [31:0] pos_out;
	logic [7:0] vector;
	logic [rcf_pkg::EVT_N-1:0] evt_en;
	logic [rcf_pkg::EVT_N-1:0] evt_stat;
	logic [rcf_pkg::EVT_N-1:0] evt_set;
	logic [rcf_pkg::EVT_N-1:0] evt_clr;
	logic busy;
	logic pmi_seen;
	rcf_pkg::rcf_state_t state;
	logic [rcf_pkg::IDX_W-1:0] idx;
	logic [rcf_pkg::IDX_W-1:0] last_idx;
	logic wr_en;
	logic go;
	logic tgt_ok;
	logic has_instr;
	logic has_data;
	logic line_inv;
	logic [31:0] rd_word;
	logic rd_hit;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// A write lands only at the edge that completes the access phase.
	assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
	assign go = wr_en && (i_paddr == rcf_pkg::OFF_CTRL) && i_pwdata[rcf_pkg::CTRL_GO_BIT];
	assign tgt_ok = (cfg_target >= rcf_pkg::TGT_INSTR) && (cfg_target <= rcf_pkg::TGT_COHERE); // [RL16]
	assign has_instr = (cfg_target != rcf_pkg::TGT_DATA);
	assign has_data = (cfg_target != rcf_pkg::TGT_INSTR);
	// The coherency target writes data lines back without dropping them, then empties the instruction side.
	assign line_inv = (cfg_target == rcf_pkg::TGT_COHERE) ? idx[rcf_pkg::IDX_W-1] : cfg_inv; // [RL1] [RL18]

	always_comb begin
		rd_hit = 1'b1;
		rd_word = rcf_pkg::RST_WORD;
		case (i_paddr)
			rcf_pkg::OFF_CTRL: begin
				rd_word[rcf_pkg::CTRL_TGT_LSB +: 3] = cfg_target;
				rd_word[rcf_pkg::CTRL_INV_BIT] = cfg_inv;
				rd_word[rcf_pkg::CTRL_POLL_BIT] = cfg_poll;
			end
			rcf_pkg::OFF_RESUME: begin
				rd_word = resume_pos;
			end
			rcf_pkg::OFF_RESULT: begin
				rd_word[7:0] = result;
				rd_word[rcf_pkg::RES_BUSY_BIT] = busy;
			end
			rcf_pkg::OFF_POS_OUT: begin
				rd_word = pos_out;
			end
			rcf_pkg::OFF_VECTOR: begin
				rd_word[7:0] = vector;
			end
			rcf_pkg::OFF_EVT_STAT: begin
				rd_word[rcf_pkg::EVT_N-1:0] = evt_stat;
			end
			rcf_pkg::OFF_EVT_EN: begin
				rd_word[rcf_pkg::EVT_N-1:0] = evt_en;
			end
			rcf_pkg::OFF_EVT_CLR: begin
				rd_word = rcf_pkg::RST_WORD;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// The answer is registered, costing no wait state: ready rises on the first access cycle.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready <= 1'b0;
			o_prdata <= rcf_pkg::RST_WORD;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !rd_hit;
			// Data is zero outside a read's access cycle, so a refused write also answers zero.
			o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd_word : rcf_pkg::RST_WORD;
		end
	end

	// ----------------------------------------------------------------
	// Software-written registers
	// ----------------------------------------------------------------
	// Configuration is frozen while a pass runs so the walk cannot change target midway.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_target <= 3'h0;
			cfg_inv <= 1'b0;
			cfg_poll <= 1'b0;
			resume_pos <= rcf_pkg::RST_WORD;
			evt_en <= '0;
		end else if (wr_en && !busy) begin
			case (i_paddr)
				rcf_pkg::OFF_CTRL: begin
					cfg_target <= i_pwdata[rcf_pkg::CTRL_TGT_LSB +: 3];
					cfg_inv <= i_pwdata[rcf_pkg::CTRL_INV_BIT];
					cfg_poll <= i_pwdata[rcf_pkg::CTRL_POLL_BIT];
				end
				rcf_pkg::OFF_RESUME: begin
					resume_pos <= i_pwdata;
				end
				rcf_pkg::OFF_EVT_EN: begin
					evt_en <= i_pwdata[rcf_pkg::EVT_N-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// A clear is honoured even while busy, so software can drop a finished event at any time.
	assign evt_clr = (wr_en && i_paddr == rcf_pkg::OFF_EVT_CLR) ? i_pwdata[rcf_pkg::EVT_N-1:0] : '0;

	// ----------------------------------------------------------------
	// Walk sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= rcf_pkg::ST_IDLE;
			busy <= 1'b0;
			idx <= '0;
			last_idx <= '0;
			result <= rcf_pkg::ST_OK;
			pos_out <= rcf_pkg::RST_WORD;
			vector <= 8'h00;
			pmi_seen <= 1'b0;
			evt_set <= '0;
			o_line_req <= 1'b0;
			o_line_instr <= 1'b0;
			o_line_set <= '0;
			o_line_way <= '0;
			o_line_inv <= 1'b0;
			o_pf_flush_instr <= 1'b0;
			o_pf_flush_data <= 1'b0;
			o_ext_irq_ack <= 1'b0;
		end else begin
			evt_set <= '0;
			o_pf_flush_instr <= 1'b0;
			o_pf_flush_data <= 1'b0;
			o_ext_irq_ack <= 1'b0;
			if (busy && i_platform_mgmt_irq) begin
				pmi_seen <= 1'b1; // [RL10]
			end
			case (state)
				rcf_pkg::ST_IDLE: begin
					if (go && !busy) begin
						busy <= 1'b1;
						pmi_seen <= 1'b0;
						state <= rcf_pkg::ST_LAUNCH;
					end
				end
				rcf_pkg::ST_LAUNCH: begin
					// The end point is taken here, once the new target has landed, not from the old one.
					last_idx <= has_instr ? rcf_pkg::IDX_I_LAST : rcf_pkg::IDX_D_LAST; // [RL4]
					if (!tgt_ok) begin
						result <= rcf_pkg::ST_BAD_ARG; // [RL19]
						evt_set[rcf_pkg::EVT_REJECT] <= 1'b1;
						busy <= 1'b0;
						state <= rcf_pkg::ST_IDLE;
					end else if (resume_pos == rcf_pkg::RST_WORD) begin
						// A fresh pass drops older prefetches before any line is touched.
						o_pf_flush_instr <= has_instr; // [RL6]
						o_pf_flush_data <= (cfg_target == rcf_pkg::TGT_DATA) || (cfg_target == rcf_pkg::TGT_ALL);
						idx <= has_data ? rcf_pkg::IDX_D_FIRST : rcf_pkg::IDX_I_FIRST; // [RL4]
						state <= rcf_pkg::ST_ISSUE;
					end else begin
						// Position is index plus one, so zero stays free for a fresh start.
						idx <= rcf_pkg::IDX_W'(resume_pos[rcf_pkg::POS_W-1:0] - 1'b1); // [RL14] [RL5]
						state <= rcf_pkg::ST_ISSUE;
					end
				end
				rcf_pkg::ST_ISSUE: begin
					o_line_req <= 1'b1;
					o_line_instr <= idx[rcf_pkg::IDX_W-1];
					o_line_set <= idx[rcf_pkg::WAY_W +: rcf_pkg::SET_W];
					o_line_way <= idx[rcf_pkg::WAY_W-1:0];
					o_line_inv <= line_inv; // [RL1] [RL18]
					state <= rcf_pkg::ST_WAIT;
				end
				rcf_pkg::ST_WAIT: begin
					// The cache may take any number of cycles; the request simply stands until it answers.
					if (i_line_ack) begin
						o_line_req <= 1'b0;
						state <= rcf_pkg::ST_STEP;
					end
				end
				rcf_pkg::ST_STEP: begin
					// The pending external interrupt is looked at only here, after a line has completed; the management interrupt is latched in any busy cycle.
					if (idx == last_idx) begin
						result <= pmi_seen || i_platform_mgmt_irq ? rcf_pkg::ST_OK_PMI : rcf_pkg::ST_OK; // [RL9] [RL10]
						evt_set[rcf_pkg::EVT_DONE] <= 1'b1;
						busy <= 1'b0;
						state <= rcf_pkg::ST_IDLE;
					end else if (cfg_poll && i_ext_irq_pending) begin // [RL7] [RL17]
						result <= rcf_pkg::ST_PENDING; // [RL8]
						vector <= i_ext_irq_vector; // [RL11]
						o_ext_irq_ack <= 1'b1; // [RL11]
						pos_out <= 32'(idx) + 32'h0000_0002; // [RL13]
						evt_set[rcf_pkg::EVT_STOP] <= 1'b1;
						busy <= 1'b0;
						state <= rcf_pkg::ST_IDLE;
					end else begin
						idx <= idx + 1'b1; // [RL4]
						state <= rcf_pkg::ST_ISSUE;
					end
				end
				default: begin
					busy <= 1'b0;
					o_line_req <= 1'b0;
					state <= rcf_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Event status and interrupt
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < rcf_pkg::EVT_N; g++) begin : g_evt
			rcf_evt_bit u_evt (
				.i_clk(i_clk),
				.i_arst_n(i_arst_n),
				.i_set(evt_set[g]),
				.i_clr(evt_clr[g]),
				.o_flag(evt_stat[g])
			);
		end
	endgenerate

	// The interrupt trails the status by one cycle, keeping the output straight from a flip-flop.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(evt_stat & evt_en);
		end
	end

endmodule : rcf_flush_seq

// *** testbench/rcf_cache_model.sv ***
`timescale 1ns/10ps
module rcf_cache_model (
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic [8:0] i_idx,
	input wire logic i_inv,
	input wire logic [1:0] i_delay,
	output logic o_ack
);
	// Records every visit so that the bench can see each line touched once.
	// Translations are kept off by the caller, so nothing refills a line behind the walk.
	int visits [512];
	logic invs [512];
	int total = 0;
	logic [1:0] cnt = 2'h0;
	initial o_ack = 1'b0;
	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		if (!i_req || o_ack)
			cnt <= 2'h0;
		else if (cnt == i_delay) begin
			o_ack <= 1'b1;
			visits[i_idx] <= visits[i_idx] + 1;
			invs[i_idx] <= i_inv;
			total <= total + 1;
		end else
			cnt <= cnt + 2'h1;
	end
endmodule : rcf_cache_model

// *** testbench/rcf_flush_seq_assertions.sv ***
`timescale 1ns/10ps
module rcf_flush_seq_assertions (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic o_line_req,
	input wire logic o_line_instr,
	input wire logic [5:0] o_line_set,
	input wire logic [1:0] o_line_way,
	input wire logic o_line_inv,
	input wire logic i_line_ack,
	input wire logic o_pf_flush_instr,
	input wire logic o_pf_flush_data,
	input wire logic o_ext_irq_ack
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_error_no_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
		else $error("pslverr without pready or with data");
	a_line_held: assert property (o_line_req && !i_line_ack |=> o_line_req &&
		$stable({o_line_instr, o_line_set, o_line_way, o_line_inv})) else $error("line request not held");
	a_line_release: assert property (o_line_req && i_line_ack |=> !o_line_req)
		else $error("line request kept after ack");
	a_ack_single: assert property (o_ext_irq_ack |=> !o_ext_irq_ack)
		else $error("interrupt ack longer than a pulse");
	a_ack_after_line: assert property (o_ext_irq_ack |-> !o_line_req &&
		($past(i_line_ack, 1) || $past(i_line_ack, 2) || $past(i_line_ack, 3))) else $error("stop without a line");
	a_prefetch_pulse: assert property ((o_pf_flush_instr || o_pf_flush_data) |=>
		!o_pf_flush_instr && !o_pf_flush_data) else $error("prefetch discard longer than a pulse");
	a_prefetch_first: assert property ((o_pf_flush_instr || o_pf_flush_data) |->
		!o_line_req && !o_ext_irq_ack) else $error("prefetch discard during a line");
	c_stop: cover property (o_ext_irq_ack);
	c_error: cover property (o_pslverr);
	c_instr_line: cover property (o_line_req && i_line_ack && o_line_instr);
endmodule : rcf_flush_seq_assertions

bind rcf_flush_seq rcf_flush_seq_assertions u_chk (.i_clk, .i_arst_n, .i_psel, .i_penable, .o_pready,
	.o_prdata, .o_pslverr, .o_line_req, .o_line_instr, .o_line_set, .o_line_way, .o_line_inv, .i_line_ack,
	.o_pf_flush_instr, .o_pf_flush_data, .o_ext_irq_ack);

// *** testbench/rcf_flush_seq_tb_top.sv ***
`timescale 1ns/10ps
module rcf_flush_seq_tb_top;
	logic i_clk = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_line_ack;
	logic i_ext_irq_pending = 1'b0, i_platform_mgmt_irq = 1'b0, do_pmi = 1'b0, err, iv;
	logic [7:0] i_paddr = 8'h00, i_ext_irq_vector = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
	logic o_pready, o_pslverr, o_line_req, o_line_instr, o_line_inv, o_pf_flush_instr, o_pf_flush_data;
	logic o_ext_irq_ack, o_irq;
	logic [5:0] o_line_set;
	logic [1:0] o_line_way, dly = 2'h0, pf;
	int mismatches = 0, cmp_count = 0, seed = 39967, pfi = 0, pfd = 0, acks = 0, p0, d0, a0, pos;
	always #2 i_clk = ~i_clk;
	rcf_flush_seq u_dut (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
		.o_prdata, .o_pslverr, .o_line_req, .o_line_instr, .o_line_set, .o_line_way, .o_line_inv, .i_line_ack,
		.o_pf_flush_instr, .o_pf_flush_data, .i_ext_irq_pending, .i_ext_irq_vector, .o_ext_irq_ack,
		.i_platform_mgmt_irq, .o_irq);
	rcf_cache_model u_cache (.i_clk, .i_req(o_line_req), .i_idx({o_line_instr, o_line_set, o_line_way}),
		.i_inv(o_line_inv), .i_delay(dly), .o_ack(i_line_ack));
	always @(posedge i_clk) begin
		pfi <= pfi + int'(o_pf_flush_instr);
		pfd <= pfd + int'(o_pf_flush_data);
		acks <= acks + int'(o_ext_irq_ack);
		i_platform_mgmt_irq <= do_pmi && i_line_ack && u_cache.total == 100;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= v;
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (k >= 20) begin
			mismatches++;
			tally_and_finish();
		end
		@(posedge i_clk);
	endtask : apb
	task automatic go(input logic [2:0] t, input logic inv, input logic poll, input int res);
		int k;
		apb(1'b1, rcf_pkg::OFF_RESUME, 32'(res));
		apb(1'b1, rcf_pkg::OFF_CTRL, {1'b1, 25'h0, poll, inv, 1'b0, t});
		k = 0;
		do begin
			apb(1'b0, rcf_pkg::OFF_RESULT, 32'h0);
			k++;
		end while (rd[rcf_pkg::RES_BUSY_BIT] !== 1'b0 && k < 2000);
		if (k >= 2000) begin
			mismatches++;
			tally_and_finish();
		end
	endtask : go
	// Expected prefetch discards by target, instruction in the upper bit.
	function automatic logic [1:0] exp_pf(input logic [2:0] t);
		return {t != rcf_pkg::TGT_DATA, t == rcf_pkg::TGT_DATA || t == rcf_pkg::TGT_ALL};
	endfunction : exp_pf
	task automatic check_pass(input logic [2:0] t, input logic inv);
		for (int i = 0; i < 512; i++) begin
			chk(u_cache.visits[i], 32'((i < 256) ? t != rcf_pkg::TGT_INSTR : t != rcf_pkg::TGT_DATA));
			if (u_cache.visits[i] == 1)
				chk(32'(u_cache.invs[i]), 32'((t == rcf_pkg::TGT_COHERE) ? i[8] : inv));
			u_cache.visits[i] = 0;
		end
		u_cache.total = 0;
	endtask : check_pass
	initial begin
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		apb(1'b0, rcf_pkg::OFF_RESULT, 32'h0);
		chk(rd, rcf_pkg::RST_WORD);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		// Reserved codes; the status bit stays masked until the enable is written.
		for (int t = 0; t < 8; t++) begin
			if (t > 0 && t < 5)
				continue;
			go(3'(t), 1'b1, 1'b0, 0);
			chk({24'h0, rd[7:0]}, {24'h0, rcf_pkg::ST_BAD_ARG});
			chk(u_cache.total, 0);
		end
		apb(1'b0, rcf_pkg::OFF_EVT_STAT, 32'h0);
		chk(rd, 32'h0000_0004);
		chk(32'(o_irq), 32'h0);
		apb(1'b1, rcf_pkg::OFF_EVT_EN, 32'h0000_0004);
		@(posedge i_clk);
		chk(32'(o_irq), 32'h1);
		apb(1'b1, rcf_pkg::OFF_EVT_CLR, 32'h0000_0004);
		@(posedge i_clk);
		chk(32'(o_irq), 32'h0);
		// A pending interrupt must be ignored while polling is off.
		i_ext_irq_pending <= 1'b1;
		for (int t = 1; t < 5; t++) begin
			dly <= 2'($random(seed));
			do_pmi <= (t == 3);
			iv = 1'($random(seed));
			p0 = pfi;
			d0 = pfd;
			a0 = acks;
			go(3'(t), iv, 1'b0, 0);
			chk({24'h0, rd[7:0]}, {24'h0, (t == 3) ? rcf_pkg::ST_OK_PMI : rcf_pkg::ST_OK});
			pf = exp_pf(3'(t));
			chk(pfi - p0, 32'(pf[1]));
			chk(pfd - d0, 32'(pf[0]));
			chk(acks - a0, 0);
			check_pass(3'(t), iv);
		end
		do_pmi <= 1'b0;
		i_ext_irq_vector <= 8'($random(seed));
		pos = 0;
		p0 = pfi;
		for (int k = 0; k < 3; k++) begin
			a0 = acks;
			go(rcf_pkg::TGT_ALL, 1'b1, 1'b1, pos);
			chk({24'h0, rd[7:0]}, {24'h0, rcf_pkg::ST_PENDING});
			chk(acks - a0, 1);
			apb(1'b0, rcf_pkg::OFF_VECTOR, 32'h0);
			chk({24'h0, rd[7:0]}, {24'h0, i_ext_irq_vector});
			apb(1'b0, rcf_pkg::OFF_POS_OUT, 32'h0);
			chk(rd, 32'(k + 2));
			pos = int'(rd);
		end
		// Servicing the vector and end of interrupt are stood in for by dropping the pending interrupt before resuming.
		i_ext_irq_pending <= 1'b0;
		go(rcf_pkg::TGT_ALL, 1'b1, 1'b1, pos);
		chk({24'h0, rd[7:0]}, {24'h0, rcf_pkg::ST_OK});
		chk(pfi - p0, 1);
		check_pass(rcf_pkg::TGT_ALL, 1'b1);
		apb(1'b0, rcf_pkg::OFF_EVT_STAT, 32'h0);
		chk(rd, 32'h0000_0003);
		tally_and_finish();
	end
endmodule : rcf_flush_seq_tb_top
